// [hdl/seq_defines.svh]
// Purpose: constants for the ignition power-up sequencer
// Assumes: clk_sys at 20 MHz (50 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
// What this block does
// - Switch on only after key stays above high threshold for whole filter.
// - Relay topology: switch-on starts by enabling main relay drive.
// - Relay topology: bias only once battery exceeds UV release level.
// - Enable 5 V rail a fixed regulator start delay after biasing activates.
// - Enable 3.3 V rail about 1.0 ms after 5 V rail passes UV threshold.
// - Enable both sensor supplies in the same step as the 5 V rail.
// - Permanent topology: bias on key high, ignoring battery comparator.
// - Permanent topology: 5 V rail start delay after key filter expires.
// - Switch off when overvoltage stays asserted past its filter time.
// - Key filter for on and off lasts between 7.5 and 24 ms.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
`define CLK_PERIOD_NS 50
// Key filter 16 ms typical, inside the 7.5 to 24 ms window
`define KEY_FILTER_US 16000
`define KEY_FILTER_CYC ((`KEY_FILTER_US * 1000) / `CLK_PERIOD_NS)
`define REG_DELAY_US 200
`define REG_DELAY_CYC ((`REG_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define LOGIC_RAIL_DELAY_US 1000
`define LOGIC_RAIL_DELAY_CYC ((`LOGIC_RAIL_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define OV_FILTER_US 100
`define OV_FILTER_CYC ((`OV_FILTER_US * 1000) / `CLK_PERIOD_NS)
`define CNT_W 20
`endif

// [hdl/seq_pkg.sv]
package seq_pkg;
   typedef enum logic [2:0] {
      ST_OFF, ST_RELAY, ST_BIAS, ST_REG_WAIT, ST_RAIL_UP, ST_V3_WAIT, ST_ON
   } step_t;

   typedef struct packed {
      logic main_relay_drive;
      logic bias_en;
      logic main_5v_rail;
      logic logic_3v3_rail;
      logic sensor_supply_one;
      logic sensor_supply_two;
   } enables_t;

   typedef struct packed {
      logic key_high;
      logic battery_uv_ok;
      logic rail_uv_ok;
      logic battery_ov;
   } sense_t;
endpackage

// [hdl/level_filter.sv]
// Purpose: deglitch filter, output follows input after it holds stable
// Assumes: input synchronous to clk_sys
// Notes: any bounce restarts the count
`timescale 1ns/1ps
module level_filter #(
   parameter int unsigned CYCLES = 4,
   parameter int unsigned W = 20
) (
   input wire logic clk_sys, // system clock
   input wire logic reset, // async reset, active high
   input wire logic din, // raw level
   output logic dout // filtered level
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic out;
   } st_t;
   st_t s_q;
   st_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (din == s_q.out)
         s_d.cnt = '0;
      else if (s_q.cnt >= W'(CYCLES - 1))
      begin
         s_d.cnt = '0;
         s_d.out = din;
      end
      else
         s_d.cnt = s_q.cnt + W'(1);
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign dout = s_q.out;
endmodule

// [hdl/ignition_power_up_sequencer.sv]
// Purpose: power-up sequencing of relay, biasing and regulators from key
// Assumes: comparator inputs synchronous to clk_sys
// Notes: power-down and power latch live elsewhere; key low or overvoltage
//        simply drops all enables
`timescale 1ns/1ps
`include "seq_defines.svh"
module ignition_power_up_sequencer #(
   parameter int unsigned KEY_CYC = `KEY_FILTER_CYC,
   parameter int unsigned REG_CYC = `REG_DELAY_CYC,
   parameter int unsigned V3_CYC = `LOGIC_RAIL_DELAY_CYC,
   parameter int unsigned OV_CYC = `OV_FILTER_CYC
) (
   input wire logic clk_sys, // system clock 20 MHz
   input wire logic reset, // async reset, active high
   input wire logic permanent_supply, // 1: battery always connected
   input wire seq_pkg::sense_t sense, // comparator levels
   output seq_pkg::enables_t enables, // supply enables, registered
   output seq_pkg::step_t step // current step, registered
);
   localparam int W = `CNT_W;

   typedef struct packed {
      seq_pkg::step_t st;
      logic [W-1:0] cnt;
      logic [W-1:0] ov_cnt;
      logic ov_trip;
      seq_pkg::enables_t en;
   } state_t;
   state_t s_q;
   state_t s_d;
   logic key_flt;

   function automatic logic done(input logic [W-1:0] c, input int unsigned n);
      done = (c >= W'(n - 1));
   endfunction

   level_filter #(.CYCLES(KEY_CYC), .W(W)) u_key (
      .clk_sys(clk_sys),
      .reset(reset),
      .din(sense.key_high),
      .dout(key_flt)
   );

   always_comb
   begin
      s_d = s_q;
      s_d.cnt = s_q.cnt + W'(1);
      // Key low clears the trip first, so an overvoltage that is still
      // filtered in the same cycle sets it again: the set wins
      if (!key_flt)
         s_d.ov_trip = 1'b0;
      // Overvoltage filter, saturating
      if (!sense.battery_ov)
         s_d.ov_cnt = '0;
      else if (!done(s_q.ov_cnt, OV_CYC))
         s_d.ov_cnt = s_q.ov_cnt + W'(1);
      else
         s_d.ov_trip = 1'b1;
      case (s_q.st)
         seq_pkg::ST_OFF:
         begin
            s_d.en = '0;
            s_d.cnt = '0;
            if (key_flt && !s_q.ov_trip)
               s_d.st = permanent_supply ? seq_pkg::ST_BIAS
                                         : seq_pkg::ST_RELAY;
         end
         seq_pkg::ST_RELAY:
         begin
            s_d.en.main_relay_drive = 1'b1;
            s_d.cnt = '0;
            if (sense.battery_uv_ok)
               s_d.st = seq_pkg::ST_BIAS;
         end
         seq_pkg::ST_BIAS:
         begin
            // Permanent supply biases straight from the key; the relay
            // still closes so it can switch the loads
            s_d.en.main_relay_drive = 1'b1;
            s_d.en.bias_en = 1'b1;
            s_d.cnt = '0;
            s_d.st = seq_pkg::ST_REG_WAIT;
         end
         seq_pkg::ST_REG_WAIT:
            if (done(s_q.cnt, REG_CYC))
               s_d.st = seq_pkg::ST_RAIL_UP;
         seq_pkg::ST_RAIL_UP:
         begin
            s_d.en.main_5v_rail = 1'b1;
            s_d.en.sensor_supply_one = 1'b1;
            s_d.en.sensor_supply_two = 1'b1;
            s_d.cnt = '0;
            if (sense.rail_uv_ok)
               s_d.st = seq_pkg::ST_V3_WAIT;
         end
         seq_pkg::ST_V3_WAIT:
            if (done(s_q.cnt, V3_CYC))
               s_d.st = seq_pkg::ST_ON;
         seq_pkg::ST_ON:
            s_d.en.logic_3v3_rail = 1'b1;
         default:
            s_d.st = seq_pkg::ST_OFF;
      endcase
      if (s_q.st != seq_pkg::ST_OFF && (!key_flt || s_d.ov_trip))
      begin
         s_d.st = seq_pkg::ST_OFF;
         s_d.en = '0;
         s_d.cnt = '0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.st <= seq_pkg::ST_OFF;
      end
      else
         s_q <= s_d;
   end

   assign enables = s_q.en;
   assign step = s_q.st;

   off_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
      s_q.st == seq_pkg::ST_OFF |=> enables == '0)
      else $error("enables active while off");

   relay_first_a: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(enables.bias_en) && !permanent_supply |->
         $past(enables.main_relay_drive))
      else $error("bias before relay");

   bias_battery_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      $rose(enables.bias_en) && !permanent_supply |->
         $past(sense.battery_uv_ok, 2))
      else $error("bias without battery");

   rail_delay_a: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(enables.bias_en) |-> !enables.main_5v_rail [*2])
      else $error("5V rail too early");

   sensors_with_rail_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      enables.main_5v_rail == enables.sensor_supply_one &&
      enables.sensor_supply_one == enables.sensor_supply_two)
      else $error("sensor supplies out of step");

   v3_after_rail_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      enables.logic_3v3_rail |-> enables.main_5v_rail && enables.bias_en)
      else $error("3V3 without 5V");

   key_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      !key_flt && s_q.st != seq_pkg::ST_OFF |=> s_q.st == seq_pkg::ST_OFF)
      else $error("not off after key low");

   ov_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      s_q.ov_trip |=> enables == '0)
      else $error("still on after overvoltage");

   order_a: assert property (@(posedge clk_sys) disable iff (reset)
      s_q.st == seq_pkg::ST_V3_WAIT |-> $past(s_q.st) inside
         {seq_pkg::ST_RAIL_UP, seq_pkg::ST_V3_WAIT})
      else $error("step skipped");

   // Each step after off is reached only from its predecessor (bias also straight from off) or by staying put
   relay_order_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      s_q.st == seq_pkg::ST_RELAY |-> $past(s_q.st) inside
         {seq_pkg::ST_OFF, seq_pkg::ST_RELAY})
      else $error("relay step out of order");

   bias_order_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      s_q.st == seq_pkg::ST_BIAS |-> $past(s_q.st) inside
         {seq_pkg::ST_OFF, seq_pkg::ST_RELAY})
      else $error("bias step out of order");

   reg_order_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      s_q.st == seq_pkg::ST_REG_WAIT |-> $past(s_q.st) inside
         {seq_pkg::ST_BIAS, seq_pkg::ST_REG_WAIT})
      else $error("regulator wait out of order");

   rail_order_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      s_q.st == seq_pkg::ST_RAIL_UP |-> $past(s_q.st) inside
         {seq_pkg::ST_REG_WAIT, seq_pkg::ST_RAIL_UP})
      else $error("rail step out of order");

   on_order_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      s_q.st == seq_pkg::ST_ON |-> $past(s_q.st) inside
         {seq_pkg::ST_V3_WAIT, seq_pkg::ST_ON})
      else $error("on step out of order");

   // The filtered key may only move towards the level the pin holds
   key_filter_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      $changed(key_flt) |-> key_flt == $past(sense.key_high))
      else $error("key filter moved against the pin");

   key_first_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      $rose(enables.main_relay_drive) |-> $past(key_flt, 2))
      else $error("relay without filtered key");

   relay_alone_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      $rose(enables.main_relay_drive) && !permanent_supply |->
         !enables.bias_en && !enables.main_5v_rail)
      else $error("relay not first in relay topology");

   // Permanent supply goes straight from off to biasing
   perm_bias_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      $rose(enables.bias_en) && permanent_supply |->
         $past(s_q.st, 2) == seq_pkg::ST_OFF)
      else $error("permanent bias waited");

   rails_need_bias_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      !enables.bias_en |-> !enables.main_5v_rail && !enables.logic_3v3_rail)
      else $error("regulator on without biasing");

   ov_cause_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      $rose(s_q.ov_trip) |-> $past(sense.battery_ov))
      else $error("trip without overvoltage");

   // A latched trip refuses switch-on until the key goes low
   ov_refuse_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      s_q.ov_trip && s_q.st == seq_pkg::ST_OFF |=>
         s_q.st == seq_pkg::ST_OFF)
      else $error("switch-on while tripped");
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the ignition power-up sequencer
// Assumes: small filter and delay counts set through the parameters
// Notes: inputs change 2 ns after the rising edge of clk_sys
`timescale 1ns/1ps
module tb_top;
   localparam int KC = 6;
   localparam int RC = 5;
   localparam int VC = 8;
   localparam int OC = 4;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic permanent_supply = 1'b0;
   seq_pkg::sense_t sense = '0;
   seq_pkg::enables_t enables;
   seq_pkg::step_t step;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n;
   always #25 clk_sys = ~clk_sys;
   ignition_power_up_sequencer #(.KEY_CYC(KC), .REG_CYC(RC), .V3_CYC(VC),
      .OV_CYC(OC)) u_ignition_power_up_sequencer (.clk_sys(clk_sys),
      .reset(reset), .permanent_supply(permanent_supply), .sense(sense),
      .enables(enables), .step(step));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #2;
   endtask
   // Counts edges until one enable bit goes high, bounded by lim
   task automatic rise(input int idx, input int lim, output int c);
      c = 0;
      while (enables[idx] !== 1'b1 && c < lim)
      begin
         tick(1);
         c++;
      end
   endtask
   task automatic t_relay_topology();
      sense.key_high = 1'b1;
      tick(KC - 2);
      sense.key_high = 1'b0;
      tick(KC + 4);
      check({2'h0, enables}, 8'h00, "short key");
      sense.rail_uv_ok = 1'b1;
      sense.key_high = 1'b1;
      rise(5, KC + 6, n);
      check({2'h0, enables}, 8'h20, "relay first");
      tick(6);
      check({2'h0, enables}, 8'h20, "bias waits battery");
      sense.battery_uv_ok = 1'b1;
      rise(4, 4, n);
      check({2'h0, enables}, 8'h30, "bias on");
      rise(3, RC + 4, n);
      check(8'(n), 8'(RC + 1), "5v delay");
      check({2'h0, enables}, 8'h3b, "sensors with 5v");
      rise(2, VC + 4, n);
      check(8'(n), 8'(VC + 1), "3v3 delay");
      check({2'h0, enables}, 8'h3f, "all on");
      $display("t_relay_topology done");
   endtask
   task automatic t_overvoltage();
      sense.battery_ov = 1'b1;
      tick(OC - 2);
      sense.battery_ov = 1'b0;
      tick(4);
      check({2'h0, enables}, 8'h3f, "short ov ignored");
      sense.battery_ov = 1'b1;
      n = 0;
      while (enables !== 6'h00 && n < OC + 4)
      begin
         tick(1);
         n++;
      end
      check(8'(n), 8'(OC), "ov filter time");
      check({2'h0, enables}, 8'h00, "ov trip");
      check({5'h00, step}, {5'h00, seq_pkg::ST_OFF}, "ov step off");
      sense.battery_ov = 1'b0;
      tick(KC + 4);
      check({2'h0, enables}, 8'h00, "trip latched");
      sense.key_high = 1'b0;
      tick(KC + 4);
      sense.key_high = 1'b1;
      rise(2, KC + RC + VC + 12, n);
      check({2'h0, enables}, 8'h3f, "restart after key");
      $display("t_overvoltage done");
   endtask
   task automatic t_permanent();
      sense.key_high = 1'b0;
      tick(KC - 2);
      sense.key_high = 1'b1;
      tick(4);
      check({2'h0, enables}, 8'h3f, "short key drop");
      sense.key_high = 1'b0;
      tick(KC + 4);
      check({2'h0, enables}, 8'h00, "key off");
      permanent_supply = 1'b1;
      sense.battery_uv_ok = 1'b0;
      sense.key_high = 1'b1;
      rise(4, KC + 6, n);
      check({7'h00, enables[4]}, 8'h01, "bias without battery");
      check({7'h00, enables[3]}, 8'h00, "5v not yet");
      rise(3, RC + 4, n);
      check(8'(n), 8'(RC + 1), "5v after filter");
      reset = 1'b1;
      tick(1);
      check({2'h0, enables}, 8'h00, "mid-run reset");
      reset = 1'b0;
      tick(2);
      check({2'h0, enables}, 8'h00, "filter restarts");
      check({5'h00, step}, {5'h00, seq_pkg::ST_OFF}, "off after reset");
      tick(KC + 4);
      check({2'h0, enables}, 8'h30, "bias after reset");
      $display("t_permanent done");
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      tick(4);
      reset = 1'b0;
      tick(1);
      check({2'h0, enables}, 8'h00, "after reset");
      t_relay_topology();
      t_overvoltage();
      t_permanent();
      conclude();
   end
   // Whole run is under two hundred cycles, so 1 ms means a hang
   initial
   begin
      #1000000;
      n_mismatch++;
      conclude();
   end
endmodule
